// ==== sfw_flash_cmd.sv ====
`timescale 1ns/10ps

// Function
// - Dual data: lane 1 bits 7,5,3,1; lane 0 bits 6,4,2,0; MSB pair first.
// - Quad data: byte over two clocks, lane n bit n+4 then bit n.
// - Quad I/O read: four don't-care clocks after mode, then high nibble first.
// - Security address: bits 23..16 zero, 15..9 select register, 8..0 byte.
// - Write-enable opcode sets the write latch.
// - Write-disable opcode clears the write latch.
// - Latch clears at power-up, disable, any program, erase or non-volatile status write completion, software reset.
// - Volatile enable precedes status write, sets no latch, writes volatile copies only.
// - Status reads accepted anytime; 05 gives low byte, 35 high byte.
// - Status bit 0 is one while program, erase or status write runs.
// - Bit 1 mirrors latch; with it clear, writes and erases are rejected, except a status write right after volatile enable.
// - Block-guard bits 6..2 gate chip erase only; writable unless lock bits 8..7 lock status.
// - Chip erase runs only when guard bits protect nothing.
// - Lock bits: 00 open, 01 follows protect pin, 10 power lock, 11 permanent.
// - Power lock value returns to unprotected after power cycle.
// - Quad-enable bit 9 defaults zero; set, protect and hold pins become lanes.
// - Bits 13..11 are one-time locks making each security register read-only.
// - Bit 14 inverts guard region selection, default zero.
// - Bits 15 and 10 flag erase and program suspension, read only.
module sfw_flash_cmd
    import sfw_pkg::*;
#(
    parameter int STAT_WR_CYC = (sfw_pkg::T_STAT_WR_NS + sfw_pkg::CLK_NS - 1) / sfw_pkg::CLK_NS,
    parameter int PROG_CYC = (sfw_pkg::T_PROG_NS + sfw_pkg::CLK_NS - 1) / sfw_pkg::CLK_NS
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic [7:0] array_byte,
    output logic [15:0] status_word
);
    import sfw_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_RUN, S_PAUSE} sfw_state_t;

    // ------------------------------------------------------------
    // Link domain: frame capture on rising serial clock
    // ------------------------------------------------------------
    logic lrst;
    logic [6:0] cnt_q;
    logic [7:0] op_q;
    logic [31:0] adr_q;
    logic [15:0] dat_q;
    logic [6:0] len_q;
    logic fr_tgl_q;
    logic [15:0] stat_l_q;
    logic [3:0] out_q;
    logic [3:0] oe_q;
    logic [15:0] shad_q;

    assign lrst = rst | cs_n;

    always_ff @(posedge sclk or posedge lrst)
    begin
        if (lrst)
        begin
            cnt_q <= 7'h00;
        end
        else if (cnt_q == CNT_TOP)
        begin
            cnt_q <= CNT_WRAP;
        end
        else
        begin
            cnt_q <= cnt_q + 7'h01;
        end
    end

    // Held after chip select rises; the core reads them only then
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            op_q <= 8'h00;
            adr_q <= 32'h0000_0000;
            dat_q <= 16'h0000;
            len_q <= 7'h00;
            fr_tgl_q <= 1'b0;
        end
        else
        begin
            len_q <= cnt_q + 7'h01;
            if (cnt_q == 7'h00)
            begin
                fr_tgl_q <= ~fr_tgl_q;
            end
            if (cnt_q < N_OP)
            begin
                op_q <= {op_q[6:0], io_in[0]};
            end
            else if (op_q == OP_DUAL_RD)
            begin
                if (cnt_q < N_ADR2_END)
                begin
                    adr_q <= {adr_q[29:0], io_in[1], io_in[0]};
                end
            end
            else if (op_q == OP_QUAD_RD && stat_l_q[ST_QE])
            begin
                if (cnt_q < N_ADR4_END)
                begin
                    adr_q <= {adr_q[27:0], io_in};
                end
            end
            else if (cnt_q < N_ADR1_END)
            begin
                adr_q <= {adr_q[30:0], io_in[0]};
            end
            if (cnt_q >= N_OP && cnt_q < N_WR16)
            begin
                dat_q <= {dat_q[14:0], io_in[0]};
            end
        end
    end

    // Status snapshot at the last opcode edge; the core holds the shadow while the frame is open
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            stat_l_q <= ST_RESET;
        end
        else if (cnt_q == N_OP - 7'h01)
        begin
            stat_l_q <= shad_q;
        end
    end

    // ------------------------------------------------------------
    // Link domain: output lanes on falling serial clock
    // ------------------------------------------------------------
    always_ff @(negedge sclk or posedge lrst)
    begin
        if (lrst)
        begin
            out_q <= 4'h0;
            oe_q <= 4'h0;
        end
        else if (cnt_q >= N_OP && op_q == OP_STAT_LO)
        begin
            oe_q <= 4'h2;
            out_q <= {2'h0, stat_l_q[{1'b0, ~cnt_q[2:0]}], 1'b0};
        end
        else if (cnt_q >= N_OP && op_q == OP_STAT_HI)
        begin
            oe_q <= 4'h2;
            out_q <= {2'h0, stat_l_q[{1'b1, ~cnt_q[2:0]}], 1'b0};
        end
        else if (cnt_q >= N_DUAL_DATA && op_q == OP_DUAL_RD)
        begin
            oe_q <= 4'h3;
            out_q <= {2'h0, array_byte[{~cnt_q[1:0], 1'b1}], array_byte[{~cnt_q[1:0], 1'b0}]};
        end
        else if (cnt_q >= N_QUAD_DATA && op_q == OP_QUAD_RD && stat_l_q[ST_QE])
        begin
            oe_q <= 4'hF;
            out_q <= cnt_q[0] ? array_byte[3:0] : array_byte[7:4];
        end
        else
        begin
            oe_q <= 4'h0;
            out_q <= 4'h0;
        end
    end

    assign io_out = out_q;
    assign io_oe = oe_q;

    // ------------------------------------------------------------
    // Core domain: frame end detection
    // ------------------------------------------------------------
    logic cs_s;
    logic cs_p_q;
    logic seen_q;
    logic wp_s;
    logic ev;

    sfw_sync cs_sync
    (
        .clock(clock),
        .rst(rst),
        .d(cs_n),
        .q_q(cs_s)
    );

    sfw_sync wp_sync
    (
        .clock(clock),
        .rst(rst),
        .d(io_in[2]),
        .q_q(wp_s)
    );

    // A chip select pulse with no clocks leaves the toggle unchanged
    assign ev = cs_s & ~cs_p_q & (fr_tgl_q != seen_q);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cs_p_q <= 1'b1;
            seen_q <= 1'b0;
        end
        else
        begin
            cs_p_q <= cs_s;
            if (ev)
            begin
                seen_q <= fr_tgl_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Core domain: command decode
    // ------------------------------------------------------------
    sfw_state_t st_q;
    sfw_kind_t kind_q;
    logic [19:0] tmr_q;
    logic [15:0] pend_q;
    logic [15:0] vol_q;
    logic [15:0] nv_q;
    logic latch_q;
    logic varm_q;
    logic rsten_q;
    logic [15:0] status_q;
    logic [1:0] srp;
    logic locked;
    logic [15:0] wd;
    logic [15:0] new_v;
    logic [15:0] new_n;
    logic is_erase;
    logic is_pe;
    logic sec_ok;
    logic [2:0] sec_sel;
    logic guard_ok;
    logic wr_ok;
    logic pe_ok;
    logic done;
    logic soft_rst;
    logic pause_ev;
    logic resume_ev;

    assign srp = {vol_q[ST_STATUS_LOCK_HI], vol_q[ST_STATUS_LOCK_LO]};
    assign locked = srp[1] | (srp == SRP_HW & ~(vol_q[ST_QE] | wp_s));
    assign wd = (len_q == N_WR16) ? {dat_q[7:0], dat_q[15:8]} : {8'h00, dat_q[7:0]};
    assign new_v = (vol_q & ~VOL_MASK) | (wd & VOL_MASK);
    assign new_n = (wd & NV_MASK) | (nv_q & LB_MASK);
    assign is_erase = op_q inside {OP_PAGE_CLR, OP_4K_CLR, OP_32K_CLR, OP_64K_CLR,
                                   OP_CHIP_CLR, OP_CHIP_CLR2, OP_OTP_CLR};
    assign is_pe = is_erase | (op_q inside {OP_PAGE_WR, OP_PAGE_WR2, OP_PAGE_WR4, OP_OTP_WR});
    assign sec_sel = {adr_q[15:9] == SEC_R3, adr_q[15:9] == SEC_R2, adr_q[15:9] == SEC_R1};
    assign sec_ok = adr_q[23:16] == SEC_HI && sec_sel != 3'h0
                    && (sec_sel & nv_q[ST_LB_LO +: 3]) == 3'h0;

    always_comb
    begin
        guard_ok = 1'b1;
        if (op_q == OP_CHIP_CLR || op_q == OP_CHIP_CLR2)
        begin
            guard_ok = vol_q[6:2] == 5'h00 && !vol_q[ST_CMP];
        end
        else if (op_q == OP_OTP_CLR || op_q == OP_OTP_WR)
        begin
            guard_ok = sec_ok;
        end
    end

    assign wr_ok = ev && op_q == OP_STAT_WR && (len_q == N_WR8 || len_q == N_WR16)
                   && st_q == S_IDLE && !locked && (latch_q || varm_q);
    assign pe_ok = ev && is_pe && latch_q && st_q == S_IDLE && guard_ok;
    assign done = st_q == S_RUN && tmr_q == 20'h00000;
    assign soft_rst = ev && op_q == OP_RST && rsten_q && len_q == N_OP;
    assign pause_ev = ev && (op_q == OP_PAUSE || op_q == OP_PAUSE2) && st_q == S_RUN && kind_q != K_STAT;
    assign resume_ev = ev && (op_q == OP_RESUME || op_q == OP_RESUME2) && st_q == S_PAUSE;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            latch_q <= 1'b0;
        end
        else if (ev && op_q == OP_LATCH_SET && len_q == N_OP)
        begin
            latch_q <= 1'b1;
        end
        else if (done || soft_rst || (ev && op_q == OP_LATCH_CLR && len_q == N_OP))
        begin
            latch_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            varm_q <= 1'b0;
            rsten_q <= 1'b0;
        end
        else if (ev)
        begin
            varm_q <= op_q == OP_VOL_ARM && len_q == N_OP;
            rsten_q <= op_q == OP_RST_EN;
        end
    end

    // ------------------------------------------------------------
    // Core domain: operation timer
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_q <= S_IDLE;
            kind_q <= K_STAT;
            tmr_q <= 20'h00000;
            pend_q <= ST_RESET;
        end
        else
        begin
            unique case (st_q)
                S_IDLE:
                begin
                    if (wr_ok && !varm_q)
                    begin
                        st_q <= S_RUN;
                        kind_q <= K_STAT;
                        tmr_q <= 20'(STAT_WR_CYC - 1);
                        pend_q <= new_n;
                    end
                    else if (pe_ok)
                    begin
                        st_q <= S_RUN;
                        kind_q <= is_erase ? K_ERASE : K_PROG;
                        tmr_q <= 20'(PROG_CYC - 1);
                    end
                end
                S_RUN:
                begin
                    if (pause_ev)
                    begin
                        st_q <= S_PAUSE;
                    end
                    else if (done)
                    begin
                        st_q <= S_IDLE;
                    end
                    else
                    begin
                        tmr_q <= tmr_q - 20'h00001;
                    end
                end
                S_PAUSE:
                begin
                    if (resume_ev)
                    begin
                        st_q <= S_RUN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Core domain: status bits
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            nv_q <= ST_RESET;
            vol_q <= ST_RESET;
        end
        else if (done && kind_q == K_STAT)
        begin
            nv_q <= pend_q;
            vol_q <= pend_q;
        end
        else if (wr_ok && varm_q)
        begin
            vol_q <= new_v;
        end
        else if (soft_rst)
        begin
            vol_q <= nv_q;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            status_q <= ST_RESET;
        end
        else
        begin
            status_q <= vol_q;
            status_q[ST_LB_LO +: 3] <= nv_q[ST_LB_LO +: 3];
            status_q[ST_ESUS] <= st_q == S_PAUSE && kind_q == K_ERASE;
            status_q[ST_PSUS] <= st_q == S_PAUSE && kind_q == K_PROG;
            status_q[1] <= latch_q;
            status_q[ST_BUSY] <= st_q == S_RUN;
        end
    end

    assign status_word = status_q;

    // Shadow frozen a few clocks after select falls; the opcode takes longer than that
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            shad_q <= ST_RESET;
        end
        else if (cs_s)
        begin
            shad_q <= status_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    latch_set_a: assert property (ev && op_q == OP_LATCH_SET && len_q == N_OP |=> ##1 status_q[1])
        else $error("write latch not set");
    latch_clear_a: assert property (ev && op_q == OP_LATCH_CLR && len_q == N_OP && !done |=> !latch_q)
        else $error("write latch not cleared");
    done_clear_a: assert property (done && !ev |=> !latch_q && st_q == S_IDLE)
        else $error("completion left latch set");
    busy_bit_a: assert property (st_q == S_RUN && !done && !pause_ev |=> ##1 status_q[ST_BUSY])
        else $error("busy bit low while running");
    no_latch_a: assert property (ev && is_pe && !latch_q && st_q == S_IDLE |=> st_q == S_IDLE)
        else $error("operation started without latch");
    chip_guard_a: assert property (ev && op_q == OP_CHIP_CLR && vol_q[6:2] != 5'h00 |=> st_q != S_RUN || $past(st_q) == S_RUN)
        else $error("guarded chip erase started");
    lock_write_a: assert property (ev && op_q == OP_STAT_WR && locked && !done |=> $stable(vol_q))
        else $error("locked status changed");
    otp_sticky_a: assert property ((nv_q & LB_MASK) != 16'h0000 |=> (nv_q & $past(nv_q) & LB_MASK) == ($past(nv_q) & LB_MASK))
        else $error("one-time lock bit cleared");
    vol_arm_a: assert property (ev && op_q == OP_VOL_ARM && !latch_q |=> !latch_q && varm_q)
        else $error("volatile enable misbehaved");
    pause_flag_a: assert property (pause_ev && kind_q == K_ERASE |=> ##1 status_q[ST_ESUS] && !status_q[ST_BUSY])
        else $error("erase pause flag missing");

    stat_wr_c: cover property (wr_ok && !varm_q ##1 st_q == S_RUN);
    prog_done_c: cover property (done && kind_q == K_PROG);
    pause_c: cover property (pause_ev ##[1:200] resume_ev);
endmodule

// ==== sfw_sync.sv ====
`timescale 1ns/10ps

package sfw_pkg;
    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_VOL_ARM = 8'h50;
    localparam logic [7:0] OP_STAT_LO = 8'h05;
    localparam logic [7:0] OP_STAT_HI = 8'h35;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_DUAL_RD = 8'hBB;
    localparam logic [7:0] OP_QUAD_RD = 8'hEB;
    localparam logic [7:0] OP_PAGE_WR = 8'h02;
    localparam logic [7:0] OP_PAGE_WR2 = 8'hA2;
    localparam logic [7:0] OP_PAGE_WR4 = 8'h32;
    localparam logic [7:0] OP_PAGE_CLR = 8'h81;
    localparam logic [7:0] OP_4K_CLR = 8'h20;
    localparam logic [7:0] OP_32K_CLR = 8'h52;
    localparam logic [7:0] OP_64K_CLR = 8'hD8;
    localparam logic [7:0] OP_CHIP_CLR = 8'h60;
    localparam logic [7:0] OP_CHIP_CLR2 = 8'hC7;
    localparam logic [7:0] OP_OTP_CLR = 8'h44;
    localparam logic [7:0] OP_OTP_WR = 8'h42;
    localparam logic [7:0] OP_PAUSE = 8'h75;
    localparam logic [7:0] OP_PAUSE2 = 8'hB0;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_RESUME2 = 8'h30;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam int ST_BUSY = 0;
    localparam int ST_STATUS_LOCK_LO = 7;
    localparam int ST_STATUS_LOCK_HI = 8;
    localparam int ST_QE = 9;
    localparam int ST_PSUS = 10;
    localparam int ST_LB_LO = 11;
    localparam int ST_CMP = 14;
    localparam int ST_ESUS = 15;
    localparam logic [15:0] VOL_MASK = 16'h43FC;
    localparam logic [15:0] NV_MASK = 16'h7BFC;
    localparam logic [15:0] LB_MASK = 16'h3800;
    localparam logic [15:0] ST_RESET = 16'h0000;
    localparam logic [1:0] SRP_HW = 2'h1;
    // ------------------------------------------------------------
    // Link bit counts (edges since chip select fell)
    // ------------------------------------------------------------
    localparam logic [6:0] N_OP = 7'h08;
    localparam logic [6:0] N_WR8 = 7'h10;
    localparam logic [6:0] N_WR16 = 7'h18;
    localparam logic [6:0] N_ADR1_END = 7'h20;
    localparam logic [6:0] N_ADR2_END = 7'h18;
    localparam logic [6:0] N_ADR4_END = 7'h10;
    localparam logic [6:0] N_DUAL_DATA = 7'h18;
    localparam logic [6:0] N_QUAD_DATA = 7'h14;
    localparam logic [6:0] CNT_TOP = 7'h7F;
    localparam logic [6:0] CNT_WRAP = 7'h78;
    // ------------------------------------------------------------
    // Security register selection
    // ------------------------------------------------------------
    localparam logic [7:0] SEC_HI = 8'h00;
    localparam logic [6:0] SEC_R1 = 7'h08;
    localparam logic [6:0] SEC_R2 = 7'h10;
    localparam logic [6:0] SEC_R3 = 7'h18;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int T_STAT_WR_NS = 100000;
    localparam int T_PROG_NS = 200000;
    typedef enum logic [1:0] {K_STAT, K_PROG, K_ERASE} sfw_kind_t;
endpackage

module sfw_sync
(
    input wire logic clock,
    input wire logic rst,
    input wire logic d,
    output logic q_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            q_q <= 1'b1;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
            begin
                q_q <= s3_q;
            end
        end
    end
endmodule

// ==== sfw_host.sv ====
`timescale 1ns/10ps

// ----------------------------------------
// Host controller at the far side of the link
// ----------------------------------------
module sfw_host
(
    input wire logic [3:0] io,
    output logic sclk,
    output logic cs_n,
    output logic [3:0] drv
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        drv = 4'hF;
    end

    // One clock: drive, rise, sample, fall; released lanes toggle
    task automatic cyc(input logic [3:0] v, input logic rel, output logic [3:0] r);
        drv = rel ? ~drv : v;
        #24 sclk = 1'b1;
        r = io;
        #24 sclk = 1'b0;
    endtask

    // Highest bits first, w lanes per clock
    task automatic send(input int w, input int nb, input logic [31:0] v);
        logic [3:0] r;
        for (int i = nb - w; i >= 0; i -= w)
        begin
            cyc(4'(v >> i) & 4'((1 << w) - 1) | (w == 4 ? 4'h0 : 4'hC), 1'b0, r);
        end
    endtask

    task automatic recv(input int w, input int n, output logic [31:0] v);
        logic [3:0] r;
        v = '0;
        repeat (n)
        begin
            cyc(4'h0, 1'b1, r);
            v = (v << w) | (w == 1 ? 32'(r[1]) : 32'(r) & 32'((1 << w) - 1));
        end
    endtask

    task automatic open_f();
        #10 cs_n = 1'b0;
        #14;
    endtask

    // Idle gap lets the core take the frame
    task automatic close_f();
        #24 cs_n = 1'b1;
        #600;
    endtask

    task automatic cmd(input logic [7:0] op);
        open_f();
        send(1, 8, 32'(op));
        close_f();
    endtask
endmodule

// ==== serial_flash_write_enable_status_bench.sv ====
`timescale 1ns/10ps

module serial_flash_write_enable_status_bench;
    import sfw_pkg::*;
    logic clock;
    logic rst;
    logic [7:0] array_byte;
    logic sclk;
    logic cs_n;
    logic [3:0] drv;
    logic [3:0] io;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic [15:0] status_word;
    logic [31:0] r;
    int fail_count;
    int cmp_count;

    // ----------------------------------------
    // Lane wires and parts
    // ----------------------------------------
    assign io = (io_oe & io_out) | (~io_oe & drv);

    sfw_flash_cmd #(.STAT_WR_CYC(20), .PROG_CYC(20)) DUT (.clock(clock), .rst(rst), .sclk(sclk),
        .cs_n(cs_n), .io_in(io), .io_out(io_out), .io_oe(io_oe), .array_byte(array_byte),
        .status_word(status_word));
    sfw_host host (.io(io), .sclk(sclk), .cs_n(cs_n), .drv(drv));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic rd(input logic [7:0] op, output logic [31:0] v);
        host.open_f();
        host.send(1, 8, 32'(op));
        host.recv(1, 8, v);
        host.close_f();
    endtask

    // Low byte goes first on the wire
    task automatic wsr(input int n, input logic [15:0] v);
        host.open_f();
        host.send(1, 8, 32'(OP_STAT_WR));
        host.send(1, n, n == 16 ? {16'h0, v[7:0], v[15:8]} : 32'(v[7:0]));
        host.close_f();
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (status_word[0] !== 1'b0 && n < 400)
        begin
            @(posedge clock);
            n++;
        end
        if (n >= 400)
        begin
            fail_count++;
            $display("[ERR] %0t busy never cleared", $time);
            test_done();
        end
    endtask

    // ----------------------------------------
    // Clock and sequence
    // ----------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial
    begin
        rst = 1'b1;
        array_byte = 8'hA5;
        fail_count = 0;
        cmp_count = 0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        chk(32'(status_word), 32'h0);
        wsr(16, 16'h0200);
        chk(32'(status_word), 32'h0);
        host.cmd(OP_LATCH_SET);
        chk(32'(status_word), 32'h2);
        rd(OP_STAT_LO, r);
        chk(r, 32'h02);
        host.cmd(OP_LATCH_CLR);
        chk(32'(status_word), 32'h0);
        host.cmd(OP_LATCH_SET);
        wsr(16, 16'h0200);
        chk(32'(status_word[1:0]), 32'h3);
        wait_idle();
        chk(32'(status_word), 32'h0200);
        rd(OP_STAT_HI, r);
        chk(r, 32'h02);
        // Quad read: nibble address, four dummies, data
        host.open_f();
        host.send(1, 8, 32'(OP_QUAD_RD));
        host.send(4, 32, 32'h0);
        host.recv(4, 4, r);
        host.recv(4, 2, r);
        host.close_f();
        chk(r, 32'hA5);
        // Dual read: paired address, paired data
        host.open_f();
        host.send(1, 8, 32'(OP_DUAL_RD));
        host.send(2, 32, 32'h0);
        host.recv(2, 4, r);
        host.close_f();
        chk(r, 32'hA5);
        host.cmd(OP_VOL_ARM);
        wsr(8, 16'h0004);
        chk(32'(status_word), 32'h0004);
        host.cmd(OP_LATCH_SET);
        host.cmd(OP_CHIP_CLR);
        chk(32'(status_word), 32'h0006);
        host.cmd(OP_VOL_ARM);
        wsr(16, 16'h0100);
        chk(32'(status_word), 32'h0102);
        host.cmd(OP_VOL_ARM);
        wsr(16, 16'h0000);
        chk(32'(status_word), 32'h0102);
        rd(OP_STAT_HI, r);
        chk(r, 32'h01);
        // Power cycle drops the power lock
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        chk(32'(status_word), 32'h0);
        host.cmd(OP_LATCH_SET);
        wsr(16, 16'h0800);
        wait_idle();
        host.cmd(OP_LATCH_SET);
        wsr(16, 16'h0000);
        wait_idle();
        chk(32'(status_word), 32'h0800);
        test_done();
    end
endmodule
